// ==== src/sld_pkg.sv ====
// serial link dma slave: shared constants, codes, states and the state record
// ============================================================================
`default_nettype none
package sld_pkg;
   // ==================== timing
   localparam int unsigned CLK_HZ = 125_000_000; // core clock
   localparam int unsigned LINK_BAUD = 4_000_000; // link bit rate
   localparam int unsigned SMP_PER_BIT = 4; // samples per bit
   localparam int unsigned SMP_CYC = CLK_HZ / (LINK_BAUD * SMP_PER_BIT); // clocks per sample
   localparam int unsigned FRAME_BITS = 11; // start, 8 data, parity, stop
   localparam int unsigned TA1_NS = 8000; // turn-around before transmit
   localparam int unsigned TA2_NS = 7000; // turn-around after transmit
   localparam int unsigned TA1_CYC = (TA1_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned TA2_CYC = (TA2_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [2:0] SMP_LAST = 3'(SMP_CYC - 1); // divider wrap
   localparam logic [9:0] TA1_LOAD = 10'(TA1_CYC - 1); // delay counter loads
   localparam logic [9:0] TA2_LOAD = 10'(TA2_CYC - 1);
   localparam logic [5:0] PRE_LOAD = 6'(FRAME_BITS * SMP_PER_BIT - 1); // quiet byte, samples
   localparam logic [2:0] GAP_MAX = 3'h6; // idle samples allowed between bytes
   localparam logic [3:0] RX_BIT_PAR = 4'h8; // receive bit index of parity
   localparam logic [3:0] TX_BIT_PAR = 4'h8; // transmit bit index before parity
   localparam logic [3:0] TX_BIT_STOP = 4'hA; // transmit stop bit index
   localparam logic PAR_ODD = 1'b0; // parity sense, 0 = even
   localparam logic [8:0] LEN_ONE = 9'h001; // short transfer
   localparam logic [8:0] LEN_PAGE = 9'h100; // page transfer
   // ==================== side bus function codes
   typedef logic [3:0] sld_fs_t;
   typedef logic [7:0] sld_byte_t;
   localparam sld_fs_t FS_NONE = 4'h0;
   localparam sld_fs_t FS_WRITE = 4'h1;
   localparam sld_fs_t FS_ADDR_HI = 4'h2;
   localparam sld_fs_t FS_ADDR_LO = 4'h3;
   localparam sld_fs_t FS_STATUS = 4'h4;
   localparam sld_fs_t FS_READ = 4'h5;
   localparam sld_fs_t FS_RESTART = 4'h7;
   // ==================== link command codes
   localparam sld_byte_t CMD_STATUS = 8'h01;
   localparam sld_byte_t CMD_RESTART = 8'h02;
   localparam sld_byte_t CMD_WR1 = 8'h10;
   localparam sld_byte_t CMD_WR256 = 8'h11;
   localparam sld_byte_t CMD_RD1 = 8'h20;
   localparam sld_byte_t CMD_RD256 = 8'h21;
   // ==================== states
   typedef enum logic [2:0] {M_IDLE = 3'h0, M_ADDR_H = 3'h1, M_ADDR_L = 3'h3, M_DATA = 3'h2,
                             M_TA1 = 3'h6, M_TX = 3'h7, M_TA2 = 3'h5} sld_main_t;
   typedef enum logic [2:0] {D_IDLE = 3'h0, D_WAIT = 3'h1, D_ARB = 3'h3, D_AH = 3'h2,
                             D_AL = 3'h6, D_LINK = 3'h7, D_SEC = 3'h5} sld_dma_t;
   typedef enum logic [1:0] {T_OFF = 2'h0, T_PRE = 2'h1, T_SHIFT = 2'h3} sld_tx_t;
   // ==================== state record
   typedef struct packed {
      sld_main_t m; sld_dma_t d; sld_tx_t t;
      logic [2:0] div; // sample divider
      logic rx_act, rx_prev, rx_perr; // receiver
      logic [1:0] rx_ph; logic [3:0] rx_bit; logic [7:0] rx_sh; logic [2:0] gap;
      logic [7:0] cmd, wdata; logic [15:0] addr; logic link_pend;
      logic [8:0] dcnt, rd_left, tx_left; logic [9:0] tcnt; logic [5:0] pre;
      logic [1:0] tph; logic [3:0] tbit; logic [7:0] tsh; logic tpar, tmem, tsp, txl, txen;
      logic [1:0][9:0] fifo_mem; logic wp, rp; logic [1:0] fifo_cnt; // {mem, parity, data}
      logic st_want; logic [1:0] stph; logic rst_p, rx_err;
   } sld_state_t;
   // ==================== decoders
   function automatic logic is_write(input sld_byte_t c);
      return (c == CMD_WR1) || (c == CMD_WR256);
   endfunction
   function automatic logic is_read(input sld_byte_t c);
      return (c == CMD_RD1) || (c == CMD_RD256);
   endfunction
   function automatic logic [8:0] xfer_len(input sld_byte_t c);
      return ((c == CMD_WR256) || (c == CMD_RD256)) ? LEN_PAGE : LEN_ONE;
   endfunction
endpackage
`default_nettype wire

// ==== src/sld_top.sv ====
// serial link dma slave: receiver, framed transmitter, turn-around, dma arbitration
`timescale 1ns/1ps
`default_nettype none
module sld_top (
   input wire logic CORE_CLK_IN,
   input wire logic RESETN_IN,
   input wire logic LINK_RX_LINE_IN,
   output logic LINK_TX_LINE_OUT,
   output logic LINK_TX_ENABLE_OUT,
   output sld_pkg::sld_fs_t FUNCTION_SELECT_LINES_OUT,
   input wire sld_pkg::sld_byte_t SIDE_PARALLEL_BUS_IN,
   output sld_pkg::sld_byte_t SIDE_PARALLEL_BUS_OUT,
   output logic SIDE_PARALLEL_BUS_OE_OUT,
   input wire logic SIDE_PARITY_IN,
   output logic BUS_REQ_OUT,
   input wire logic BUS_ACK_IN,
   output logic MEM_REQ_OUT,
   output logic MEM_WRITE_OUT,
   input wire logic DATA_VALID_IN,
   input wire logic SECONDARY_REQUESTER_ACCESS_REQ_IN,
   input wire logic SECONDARY_REQUESTER_ACCESS_WRITE_IN,
   output logic SECONDARY_REQUESTER_ACCESS_GRANT_OUT,
   output logic RECEIVE_ERROR_FLAG_OUT
);
   import sld_pkg::*;

   // ==================== state
   sld_state_t s_q; // registered state
   sld_state_t s_d; // next state
   logic smp, tick, rx_on, expect_b, byte_ok, rx_bad, push, pop, load; // per-cycle strobes
   logic [9:0] push_v; // entry entering the buffer
   logic [9:0] head_v; // entry leaving the buffer

   // ==================== next-state logic
   always_comb begin
      s_d = s_q;
      smp = (s_q.div == SMP_LAST);
      tick = smp && (s_q.tph == 2'h3);
      rx_on = (s_q.m == M_IDLE) || (s_q.m == M_ADDR_H) || (s_q.m == M_ADDR_L) || (s_q.m == M_DATA);
      expect_b = rx_on && (s_q.m != M_IDLE) && !((s_q.m == M_DATA) && (s_q.dcnt == 9'h000));
      byte_ok = 1'b0;
      rx_bad = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      load = 1'b0;
      push_v = 10'h000;
      head_v = s_q.fifo_mem[s_q.rp];
      s_d.rst_p = 1'b0;
      // sample enable divider
      s_d.div = smp ? 3'h0 : s_q.div + 3'h1;
      // receiver, only while the start detector is enabled
      if (smp && rx_on) begin
         if (!s_q.rx_act) begin
            s_d.rx_prev = LINK_RX_LINE_IN;
            if (LINK_RX_LINE_IN && s_q.rx_prev) begin
               s_d.rx_act = 1'b1;
               s_d.rx_ph = 2'h0;
               s_d.rx_bit = 4'h0;
               s_d.gap = 3'h0;
               s_d.rx_prev = 1'b0;
            end else if (expect_b) begin
               // idle samples between bytes of one command
               if (s_q.gap == GAP_MAX) rx_bad = 1'b1;
               else s_d.gap = s_q.gap + 3'h1;
            end
         end else if (s_q.rx_ph != 2'h3) begin
            s_d.rx_ph = s_q.rx_ph + 2'h1;
         end else begin
            // bit centre
            s_d.rx_ph = 2'h0;
            s_d.rx_bit = s_q.rx_bit + 4'h1;
            if (s_q.rx_bit < RX_BIT_PAR) begin
               s_d.rx_sh = {s_q.rx_sh[6:0], LINK_RX_LINE_IN};
            end else if (s_q.rx_bit == RX_BIT_PAR) begin
               s_d.rx_perr = ((^s_q.rx_sh) ^ PAR_ODD) != LINK_RX_LINE_IN;
            end else begin
               // stop bit: byte complete
               s_d.rx_act = 1'b0;
               s_d.gap = 3'h0;
               byte_ok = !s_q.rx_perr;
               rx_bad = s_q.rx_perr;
            end
         end
      end
      // dma sequencer and arbiter
      unique case (s_q.d)
         D_IDLE: if (s_q.link_pend || SECONDARY_REQUESTER_ACCESS_REQ_IN) s_d.d = D_WAIT;
         D_WAIT: if (BUS_ACK_IN) s_d.d = D_ARB;
         D_ARB: begin
            // fixed priority, a running cycle is never cut short
            if (s_q.link_pend) s_d.d = D_AH;
            else if (SECONDARY_REQUESTER_ACCESS_REQ_IN) s_d.d = D_SEC;
            else s_d.d = D_IDLE;
         end
         D_AH: s_d.d = D_AL;
         D_AL: s_d.d = D_LINK;
         D_LINK: if (DATA_VALID_IN) begin
            s_d.link_pend = 1'b0;
            s_d.addr = s_q.addr + 16'h0001;
            s_d.d = D_ARB;
            if (is_read(s_q.cmd)) begin
               push = 1'b1;
               push_v = {1'b1, SIDE_PARITY_IN, SIDE_PARALLEL_BUS_IN};
               s_d.rd_left = s_q.rd_left - 9'h001;
            end
         end
         D_SEC: if (DATA_VALID_IN) s_d.d = D_ARB;
      endcase
      // transmitter
      if (s_q.t != T_OFF && smp) s_d.tph = s_q.tph + 2'h1;
      unique case (s_q.t)
         T_OFF: ;
         T_PRE: begin
            // quiet byte with enable on, status fetched meanwhile
            if (smp && s_q.pre != 6'h00) s_d.pre = s_q.pre - 6'h01;
            if (s_q.st_want) begin
               if (s_q.stph == 2'h2) begin
                  push = 1'b1;
                  push_v = {2'b00, SIDE_PARALLEL_BUS_IN};
                  s_d.st_want = 1'b0;
                  s_d.stph = 2'h0;
                  s_d.rx_err = 1'b0;
               end else begin
                  s_d.stph = s_q.stph + 2'h1;
               end
            end
            if (tick && s_q.pre == 6'h00 && s_q.fifo_cnt != 2'h0) load = 1'b1;
         end
         T_SHIFT: if (tick) begin
            if (s_q.tbit == TX_BIT_STOP) begin
               if (s_q.tx_left != 9'h000 && s_q.fifo_cnt != 2'h0) begin
                  load = 1'b1;
               end else if (s_q.tx_left != 9'h000) begin
                  s_d.t = T_PRE;
                  s_d.txl = 1'b0;
               end else begin
                  s_d.t = T_OFF;
                  s_d.txen = 1'b0;
                  s_d.m = M_TA2;
                  s_d.tcnt = TA2_LOAD;
               end
            end else begin
               s_d.tbit = s_q.tbit + 4'h1;
               if (s_q.tbit < TX_BIT_PAR) begin
                  s_d.txl = s_q.tsh[7];
                  s_d.tsh = {s_q.tsh[6:0], 1'b0};
                  s_d.tpar = s_q.tpar ^ s_q.tsh[7];
               end else if (s_q.tbit == TX_BIT_PAR) begin
                  s_d.txl = s_q.tmem ? s_q.tsp : s_q.tpar;
               end else begin
                  s_d.txl = 1'b0;
               end
            end
         end
      endcase
      // frame load from the buffer head, start bit goes out at once
      if (load) begin
         pop = 1'b1;
         s_d.tsh = head_v[7:0];
         s_d.tsp = head_v[8];
         s_d.tmem = head_v[9];
         s_d.tpar = PAR_ODD;
         s_d.tbit = 4'h0;
         s_d.txl = 1'b1;
         s_d.t = T_SHIFT;
         s_d.tx_left = s_q.tx_left - 9'h001;
      end
      // two-entry buffer between memory fetch and transmitter
      if (push) begin
         s_d.fifo_mem[s_q.wp] = push_v;
         s_d.wp = ~s_q.wp;
      end
      if (pop) s_d.rp = ~s_q.rp;
      s_d.fifo_cnt = s_q.fifo_cnt + {1'b0, push} - {1'b0, pop};
      // read-ahead, stalled while the buffer has no room
      if ((s_q.m == M_TA1 || s_q.m == M_TX) && s_q.rd_left != 9'h000 && !s_d.link_pend &&
          s_d.fifo_cnt != 2'h2 && !push) s_d.link_pend = 1'b1;
      // command sequencer
      unique case (s_q.m)
         M_IDLE: if (byte_ok) begin
            s_d.cmd = s_q.rx_sh;
            if (s_q.rx_sh == CMD_STATUS) begin
               s_d.tx_left = LEN_ONE;
               s_d.st_want = 1'b1;
               s_d.m = M_TA1;
               s_d.tcnt = TA1_LOAD;
            end else if (s_q.rx_sh == CMD_RESTART) begin
               s_d.rst_p = 1'b1;
            end else if (is_write(s_q.rx_sh) || is_read(s_q.rx_sh)) begin
               s_d.m = M_ADDR_H;
            end
         end
         M_ADDR_H: if (byte_ok) begin
            s_d.addr[15:8] = s_q.rx_sh;
            s_d.m = M_ADDR_L;
         end
         M_ADDR_L: if (byte_ok) begin
            s_d.addr[7:0] = s_q.rx_sh;
            if (is_write(s_q.cmd)) begin
               s_d.dcnt = xfer_len(s_q.cmd);
               s_d.m = M_DATA;
            end else begin
               s_d.rd_left = xfer_len(s_q.cmd);
               s_d.tx_left = xfer_len(s_q.cmd);
               s_d.m = M_TA1;
               s_d.tcnt = TA1_LOAD;
            end
         end
         M_DATA: begin
            if (byte_ok && s_d.link_pend) begin
               rx_bad = 1'b1; // previous byte still not in memory
            end else if (byte_ok) begin
               s_d.wdata = s_q.rx_sh;
               s_d.link_pend = 1'b1;
               s_d.dcnt = s_q.dcnt - 9'h001;
            end else if (s_q.dcnt == 9'h000 && !s_q.link_pend) begin
               s_d.m = M_IDLE;
            end
         end
         M_TA1: begin
            if (s_q.tcnt == 10'h000) begin
               s_d.m = M_TX;
               s_d.t = T_PRE;
               s_d.pre = PRE_LOAD;
               s_d.tph = 2'h0;
               s_d.txen = 1'b1;
               s_d.txl = 1'b0;
               // restart the sample grid so the quiet byte lasts a full frame
               s_d.div = 3'h0;
            end else begin
               s_d.tcnt = s_q.tcnt - 10'h001;
            end
         end
         M_TX: ;
         M_TA2: begin
            if (s_q.tcnt == 10'h000) begin
               s_d.m = M_IDLE;
               s_d.rx_prev = 1'b0;
            end else begin
               s_d.tcnt = s_q.tcnt - 10'h001;
            end
         end
      endcase
      // receive fault drops the command and sets the sticky flag
      if (rx_bad) begin
         s_d.rx_err = 1'b1;
         s_d.m = M_IDLE;
         s_d.rx_act = 1'b0;
         s_d.gap = 3'h0;
      end
   end

   // ==================== state register
   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) s_q <= '0;
      else s_q <= s_d;
   end

   // ==================== pins
   always_comb begin
      SIDE_PARALLEL_BUS_OUT = 8'h00;
      SIDE_PARALLEL_BUS_OE_OUT = 1'b0;
      if (s_q.d == D_AH) begin
         FUNCTION_SELECT_LINES_OUT = FS_ADDR_HI;
         SIDE_PARALLEL_BUS_OUT = s_q.addr[15:8];
         SIDE_PARALLEL_BUS_OE_OUT = 1'b1;
      end else if (s_q.d == D_AL) begin
         FUNCTION_SELECT_LINES_OUT = FS_ADDR_LO;
         SIDE_PARALLEL_BUS_OUT = s_q.addr[7:0];
         SIDE_PARALLEL_BUS_OE_OUT = 1'b1;
      end else if (s_q.d == D_LINK && is_write(s_q.cmd)) begin
         FUNCTION_SELECT_LINES_OUT = FS_WRITE;
         SIDE_PARALLEL_BUS_OUT = s_q.wdata;
         SIDE_PARALLEL_BUS_OE_OUT = 1'b1;
      end else if (s_q.d == D_LINK) begin
         FUNCTION_SELECT_LINES_OUT = FS_READ;
      end else if (s_q.stph != 2'h0) begin
         FUNCTION_SELECT_LINES_OUT = FS_STATUS;
      end else if (s_q.rst_p) begin
         FUNCTION_SELECT_LINES_OUT = FS_RESTART;
      end else begin
         FUNCTION_SELECT_LINES_OUT = FS_NONE;
      end
   end
   assign LINK_TX_LINE_OUT = s_q.txl;
   assign LINK_TX_ENABLE_OUT = s_q.txen;
   assign BUS_REQ_OUT = (s_q.d != D_IDLE);
   assign MEM_REQ_OUT = (s_q.d == D_LINK) || (s_q.d == D_SEC);
   assign MEM_WRITE_OUT = ((s_q.d == D_LINK) && is_write(s_q.cmd)) ||
                          ((s_q.d == D_SEC) && SECONDARY_REQUESTER_ACCESS_WRITE_IN);
   assign SECONDARY_REQUESTER_ACCESS_GRANT_OUT = (s_q.d == D_SEC);
   assign RECEIVE_ERROR_FLAG_OUT = s_q.rx_err;

   // ==================== checks
   logic [10:0] dwell_q; // cycles spent in the current main state
   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) dwell_q <= 11'h000;
      else dwell_q <= (s_q.m == s_d.m) ? dwell_q + 11'h001 : 11'h000;
   end
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RESETN_IN);
   chk_pre_quiet: assert property ((s_q.t == T_PRE) |-> (LINK_TX_ENABLE_OUT && !LINK_TX_LINE_OUT))
      else $error("line not quiet before frame");
   chk_start_bit: assert property ($rose(s_q.t == T_SHIFT) |-> LINK_TX_LINE_OUT [*8])
      else $error("start bit wrong");
   chk_stop_low: assert property ((s_q.t == T_SHIFT && s_q.tbit == TX_BIT_STOP) |-> !LINK_TX_LINE_OUT)
      else $error("stop bit not inactive");
   chk_ta1_len: assert property ((s_q.m == M_TX && $past(s_q.m) == M_TA1) |->
      ($past(dwell_q) == 11'(TA1_CYC - 1))) else $error("turn-around 1 length");
   chk_ta2_len: assert property ((s_q.m == M_IDLE && $past(s_q.m) == M_TA2) |->
      ($past(dwell_q) == 11'(TA2_CYC - 1))) else $error("turn-around 2 length");
   chk_bus_request: assert property ((s_q.d == D_IDLE && s_q.link_pend) |=> BUS_REQ_OUT [*2])
      else $error("bus request missing");
   chk_link_first: assert property ((s_q.d == D_ARB && s_q.link_pend) |=> ##1 (s_q.d == D_AL) ##1 MEM_REQ_OUT)
      else $error("link request not first");
   chk_sec_excl: assert property ($rose(SECONDARY_REQUESTER_ACCESS_GRANT_OUT) |-> !$past(s_q.link_pend))
      else $error("secondary granted over link");
   chk_read_strobe: assert property ((s_q.d == D_LINK && !is_write(s_q.cmd)) |->
      (MEM_REQ_OUT && !MEM_WRITE_OUT && FUNCTION_SELECT_LINES_OUT == FS_READ)) else $error("read cycle strobes");
   chk_ack_arb: assert property ((s_q.d == D_WAIT && BUS_ACK_IN) |=> (s_q.d == D_ARB) ##1 (s_q.d != D_WAIT))
      else $error("no arbitration at acknowledge");
   cov_status: cover property ((s_q.m == M_TA2) && $past(s_q.cmd) == CMD_STATUS);
   cov_page_read: cover property ($fell(s_q.m == M_TX) && s_q.cmd == CMD_RD256);
   cov_sec_grant: cover property ($rose(SECONDARY_REQUESTER_ACCESS_GRANT_OUT));
   cov_rx_error: cover property ($rose(RECEIVE_ERROR_FLAG_OUT));
endmodule
`default_nettype wire

// ==== sim/sld_host_model.sv ====
// host end of the serial link: frames command bytes out and captures answer frames
`timescale 1ns/1ps
`default_nettype none
module sld_host_model (
   input wire logic clk_in,
   input wire logic line_in,
   input wire logic en_in,
   output logic line_out
);
   import sld_pkg::*;
   localparam int BIT_CYC = SMP_CYC * SMP_PER_BIT; // clocks per bit
   initial line_out = 1'h0; // idle line low
   // ====================
   // one frame: start, data msb first, parity (spoiled on request), stop
   task automatic send_byte(input logic [7:0] b, input logic bad);
      logic [10:0] f;
      f = {1'h1, b, (^b) ^ PAR_ODD ^ bad, 1'h0};
      for (int i = 10; i >= 0; i--) begin
         line_out <= f[i];
         repeat (BIT_CYC) @(posedge clk_in);
      end
   endtask
   // ====================
   // waits for a start bit, then samples data, parity and stop at bit centres
   task automatic recv_byte(output logic [9:0] r, output int quiet);
      quiet = 0;
      while (!(line_in === 1'h1 && en_in === 1'h1) && quiet < 5000) begin
         @(posedge clk_in);
         quiet++;
      end
      repeat (BIT_CYC / 2) @(posedge clk_in);
      for (int i = 9; i >= 0; i--) begin
         repeat (BIT_CYC) @(posedge clk_in);
         r[i] = line_in;
      end
   endtask
endmodule
`default_nettype wire

// ==== sim/serial_link_dma_slave_bench.sv ====
// bench for the serial link dma slave: host model on the link, memory responder on the bus
`timescale 1ns/1ps
`default_nettype none
module serial_link_dma_slave_bench;
   import sld_pkg::*;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic ack = 1'h0, dv = 1'h0, par = 1'h0, sreq = 1'h0, swr = 1'h0;
   logic rx, txl, txen, oe, breq, mreq, mw, gnt, rerr;
   sld_fs_t fs;
   sld_byte_t din = 8'h00, dout, a_hi, a_lo, wdat;
   sld_byte_t stat_b = 8'hA5, mem_b = 8'h3C; // status and memory contents
   logic [15:0] fs_seen = 16'h0000; // function codes seen
   logic mw_link, mw_sec;
   int link_dv = 0, g_after = -1, err_count = 0, n_tests = 0;
   always #4 clk = ~clk; // 125 MHz
   sld_top DUT (.CORE_CLK_IN(clk), .RESETN_IN(rst_n), .LINK_RX_LINE_IN(rx), .LINK_TX_LINE_OUT(txl),
      .LINK_TX_ENABLE_OUT(txen), .FUNCTION_SELECT_LINES_OUT(fs), .SIDE_PARALLEL_BUS_IN(din),
      .SIDE_PARALLEL_BUS_OUT(dout), .SIDE_PARALLEL_BUS_OE_OUT(oe), .SIDE_PARITY_IN(par),
      .BUS_REQ_OUT(breq), .BUS_ACK_IN(ack), .MEM_REQ_OUT(mreq), .MEM_WRITE_OUT(mw),
      .DATA_VALID_IN(dv), .SECONDARY_REQUESTER_ACCESS_REQ_IN(sreq),
      .SECONDARY_REQUESTER_ACCESS_WRITE_IN(swr), .SECONDARY_REQUESTER_ACCESS_GRANT_OUT(gnt),
      .RECEIVE_ERROR_FLAG_OUT(rerr));
   sld_host_model host (.clk_in(clk), .line_in(txl), .en_in(txen), .line_out(rx));
   // ====================
   // memory side responder and monitor
   always @(posedge clk) begin
      ack <= breq;
      dv <= mreq && !dv;
      din <= (fs == FS_STATUS) ? stat_b : mem_b;
      par <= ~^mem_b; // stored parity differs from computed on purpose
      fs_seen[fs] <= 1'h1;
      if (fs == FS_ADDR_HI) a_hi <= dout;
      if (fs == FS_ADDR_LO) a_lo <= dout;
      if (fs == FS_WRITE && oe) wdat <= dout;
      if (mreq && dv && !gnt) begin
         mw_link <= mw;
         link_dv <= link_dv + 1;
      end
      if (gnt) g_after <= link_dv;
      if (gnt && dv) begin
         mw_sec <= mw;
         sreq <= 1'h0;
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("tests=%0d errors=%0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic marks();
      #1;
      fs_seen = 16'h0000;
      link_dv = 0;
      g_after = -1;
      @(posedge clk);
   endtask
   task automatic wait_en(output int n);
      n = 0;
      while (txen !== 1'h1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic settle();
      repeat (TA2_CYC + 60) @(posedge clk);
      check(txen, 1'h0);
   endtask
   // ====================
   // scenarios
   task automatic t_reset();
      check({txl, txen, fs, oe, breq, mreq, gnt, rerr}, 16'h0000);
   endtask
   task automatic t_error();
      host.send_byte(CMD_RD1, 1'h0);
      host.send_byte(8'h12, 1'h1);
      repeat (40) @(posedge clk);
      check(rerr, 1'h1);
      check(breq, 1'h0);
   endtask
   task automatic t_status();
      logic [9:0] r;
      int q, n;
      marks();
      host.send_byte(CMD_STATUS, 1'h0);
      wait_en(n);
      check(n >= TA1_CYC - 60 && n <= TA1_CYC + 20, 1'h1);
      host.recv_byte(r, q);
      check(q >= FRAME_BITS * SMP_PER_BIT * SMP_CYC, 1'h1);
      check(r, {stat_b, ^stat_b, 1'h0});
      check(fs_seen[FS_STATUS], 1'h1);
      check(rerr, 1'h0);
      settle();
   endtask
   task automatic t_restart();
      marks();
      host.send_byte(CMD_RESTART, 1'h0);
      repeat (40) @(posedge clk);
      check(fs_seen[FS_RESTART], 1'h1);
      // a command byte with no address behind it must end as a gap error
      host.send_byte(CMD_RD1, 1'h0);
      repeat (100) @(posedge clk);
      check(rerr, 1'h1);
      check(breq, 1'h0);
   endtask
   task automatic t_read();
      logic [9:0] r;
      int q, n;
      marks();
      host.send_byte(CMD_RD1, 1'h0);
      host.send_byte(8'h12, 1'h0);
      host.send_byte(8'h34, 1'h0);
      wait_en(n);
      host.recv_byte(r, q);
      check({a_hi, a_lo}, 16'h1234);
      check(mw_link, 1'h0);
      check(fs_seen[FS_READ], 1'h1);
      check(r, {mem_b, ~^mem_b, 1'h0});
      settle();
   endtask
   task automatic t_write();
      int n;
      marks();
      swr <= 1'h1;
      host.send_byte(CMD_WR1, 1'h0);
      host.send_byte(8'h56, 1'h0);
      host.send_byte(8'h78, 1'h0);
      fork
         host.send_byte(8'h9C, 1'h0);
         begin
            wait (breq === 1'h1);
            sreq <= 1'h1;
         end
      join
      n = 0;
      while (sreq !== 1'h0 && n < 400) begin
         @(posedge clk);
         n++;
      end
      repeat (4) @(posedge clk);
      check({a_hi, a_lo}, 16'h5678);
      check(wdat, 8'h9C);
      check(mw_link, 1'h1);
      check(16'(g_after), 16'h0001);
      check(mw_sec, 1'h1);
      check(fs_seen[FS_WRITE], 1'h1);
      check(breq, 1'h0);
   endtask
   // ====================
   // watchdog and main sequence
   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      stop_test();
   end
   initial begin
      repeat (5) @(posedge clk);
      t_reset();
      repeat (5) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      t_reset();
      t_error();
      t_status();
      t_restart();
      t_read();
      t_write();
      stop_test();
   end
endmodule
`default_nettype wire
